// ==== rtc_host_trim.sv ====
// Host end: APB registers, channel configuration checks and the RC trim sequence.
// Assumes an APB master on sys_clk and a receiver that samples data on rising serial clock edges.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module rtc_host_trim #(
    parameter int REF_HALF = rtc_pkg::REF_HALF_CYC
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    rtc_link_if.host link,
    // Receiver configuration
    output logic xtalSel,
    output logic powerDown,
    output logic extClk,
    output logic [2:0] chanEn,
    output logic scanMode,
    output logic onOffMode
);
    import rtc_pkg::*;

    rtc_hstate_t state;
    logic [15:0] halfCnt;
    logic tick;
    logic [2:0] bitCnt;
    logic [6:0] refCnt;
    logic [7:0] cmdShift;
    logic extClkOn;
    logic busy;
    logic trimmed;
    logic refused;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic trimReq;
    logic trimOk;
    logic chanOk;
    logic refusedSet;

    // A configuration that breaks the channel constraints is refused whole.
    function automatic logic chan_legal(input logic [2:0] en, input logic scan, input logic onoff);
        logic low;
        logic [1:0] cnt;
        low = scan || onoff;
        cnt = 2'(en[0]) + 2'(en[1]) + 2'(en[2]);
        chan_legal = 1'b1;
        if (scan && onoff) begin
            chan_legal = 1'b0; // see (R12)
        end
        if (low && cnt == 2'h2 && en != 3'b101) begin
            chan_legal = 1'b0; // see (R10)
        end
        if (onoff && cnt == 2'h1 && en != 3'b001) begin
            chan_legal = 1'b0; // see (R11)
        end
    endfunction

    assign wrEn = psel && penable && pready && pwrite;
    assign rdEn = psel && penable && !pready && !pwrite;
    assign mapped = (paddr == CTRL_OFF) || (paddr == STAT_OFF) || (paddr == CHAN_OFF);
    assign trimReq = wrEn && paddr == CTRL_OFF && pwdata[CTRL_TRIM];
    // Trimming is pointless while the RC oscillator is off, so such a request is refused.
    assign trimOk = !busy && !xtalSel && !powerDown && !pwdata[CTRL_XTAL] && !pwdata[CTRL_PDOWN];
    assign chanOk = chan_legal(pwdata[CHAN_EN_LSB +: 3], pwdata[CHAN_SCAN], pwdata[CHAN_ONOFF]);
    assign refusedSet = (trimReq && !trimOk) || (wrEn && paddr == CHAN_OFF && !chanOk);
    assign tick = (halfCnt == 16'(REF_HALF - 1)); // see (R7)

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (rdEn) begin
            prdata <= 32'h00000000;
            unique case (paddr)
                CTRL_OFF: prdata[3:0] <= {extClkOn, 1'b0, powerDown, xtalSel};
                STAT_OFF: prdata[2:0] <= {refused, trimmed, busy};
                CHAN_OFF: prdata[4:0] <= {onOffMode, scanMode, chanEn};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {extClkOn, powerDown, xtalSel} <= {CTRL_RST[CTRL_EXTCLK], CTRL_RST[CTRL_PDOWN], CTRL_RST[CTRL_XTAL]};
        end else if (wrEn && paddr == CTRL_OFF) begin
            xtalSel <= pwdata[CTRL_XTAL];
            powerDown <= pwdata[CTRL_PDOWN];
            extClkOn <= pwdata[CTRL_EXTCLK];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {onOffMode, scanMode, chanEn} <= CHAN_RST;
        end else if (wrEn && paddr == CHAN_OFF && chanOk) begin
            chanEn <= pwdata[CHAN_EN_LSB +: 3];
            scanMode <= pwdata[CHAN_SCAN];
            onOffMode <= pwdata[CHAN_ONOFF];
        end
    end

    // Refused is sticky; a new refusal wins over a clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            refused <= 1'b0;
        end else if (refusedSet) begin
            refused <= 1'b1;
        end else if (wrEn && paddr == STAT_OFF && pwdata[STAT_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // Trimmed drops whenever the receiver's RC oscillator stops, telling software to trim again.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trimmed <= 1'b0;
        end else if (state == RTC_HOLD && tick) begin
            trimmed <= 1'b1;
        end else if (xtalSel || powerDown) begin
            trimmed <= 1'b0; // see (R4)
        end
    end

    // The divider runs free; it paces the serial clock and the external clock alike.
    always_ff @(posedge sys_clk) begin
        if (srst || tick) begin
            halfCnt <= 16'h0000;
        end else begin
            halfCnt <= halfCnt + 16'h0001;
        end
    end

    // The reference must sit near a quarter of the carrier; REF_HALF sets it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            extClk <= 1'b1;
        end else if (powerDown || !xtalSel || !extClkOn) begin
            extClk <= 1'b1; // see (R9)
        end else if (tick) begin
            extClk <= !extClk; // see (R8)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= RTC_IDLE;
            busy <= 1'b0;
            link.cs <= 1'b0;
            link.sclk <= 1'b0;
            link.serial_config_port <= 1'b0;
            bitCnt <= 3'h0;
            refCnt <= 7'h00;
            cmdShift <= 8'h00;
        end else begin
            unique case (state)
                RTC_IDLE: begin
                    if (trimReq && trimOk) begin
                        busy <= 1'b1;
                        cmdShift <= TRIM_CMD;
                        state <= RTC_SETUP;
                    end
                end
                RTC_SETUP: begin
                    if (tick) begin
                        link.cs <= 1'b1; // see (R5)
                        link.serial_config_port <= cmdShift[7];
                        cmdShift <= {cmdShift[6:0], 1'b0};
                        bitCnt <= 3'h0;
                        state <= RTC_CMD;
                    end
                end
                RTC_CMD: begin
                    if (tick) begin
                        link.sclk <= !link.sclk;
                        if (link.sclk) begin
                            bitCnt <= bitCnt + 3'h1;
                            link.serial_config_port <= cmdShift[7];
                            cmdShift <= {cmdShift[6:0], 1'b0};
                            if (bitCnt == 3'h7) begin
                                link.serial_config_port <= 1'b0;
                                refCnt <= 7'h00;
                                state <= RTC_REF;
                            end
                        end
                    end
                end
                RTC_REF: begin
                    if (tick) begin
                        link.sclk <= !link.sclk;
                        if (!link.sclk) begin
                            refCnt <= refCnt + 7'h01;
                        end else if (refCnt == 7'(REF_EDGES)) begin
                            state <= RTC_HOLD; // see (R5)
                        end
                    end
                end
                RTC_HOLD: begin
                    if (tick) begin
                        link.cs <= 1'b0;
                        busy <= 1'b0;
                        state <= RTC_IDLE;
                    end
                end
                default: begin
                    state <= RTC_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== rtc_pkg.sv ====
// Constants shared by both ends of the RC trim link, plus the host's register map and state encoding.
// Assumes a 20 MHz system clock and a serial link of chip select, serial clock and data.
// What this block does
// (R1) Crystal when select bit is one, else RC.
// (R2) Calibration starts only on the trim command.
// (R3) RC off in power down, reset, crystal.
// (R4) Trim is volatile; host recalibrates after loss. Here the host only clears trimmed, and software must request a new trim.
// (R5) Host: select, command, 65 clocks, deselect.
// (R6) New trim applies at 65th reference edge.
// (R7) Reference near a quarter of carrier frequency.
// (R8) External clock needs crystal select bit set.
// (R9) External clock held high in power down.
// (R10) Two channels in low power: 1 and 3.
// (R11) On/off mode single channel: channel 1.
// (R12) Never both low power modes together.
// (R13) Early deselect abandons calibration, keeps old trim.
package rtc_pkg;
    localparam int SYS_FREQ_HZ = 20000000;
    localparam int REF_FREQ_HZ = 32768;
    localparam int REF_HALF_CYC = SYS_FREQ_HZ / (2 * REF_FREQ_HZ);
    localparam int CMD_W = 8;
    localparam logic [7:0] TRIM_CMD = 8'hC4;
    localparam int REF_EDGES = 65;
    localparam int TRIM_W = 16;
    localparam int SYNC_W = 3;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] CHAN_OFF = 12'h008;
    localparam int CTRL_XTAL = 0;
    localparam int CTRL_PDOWN = 1;
    localparam int CTRL_TRIM = 2;
    localparam int CTRL_EXTCLK = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_TRIMMED = 1;
    localparam int STAT_REFUSED = 2;
    localparam int CHAN_EN_LSB = 0;
    localparam int CHAN_SCAN = 3;
    localparam int CHAN_ONOFF = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [4:0] CHAN_RST = 5'h07;
    typedef enum logic [2:0] {
        RTC_IDLE = 3'b000,
        RTC_SETUP = 3'b001,
        RTC_CMD = 3'b010,
        RTC_REF = 3'b011,
        RTC_HOLD = 3'b100
    } rtc_hstate_t;
endpackage

// ==== rtc_link_if.sv ====
// Serial configuration link between the trimming host and the receiver's clock logic.
// Assumes the host makes the serial clock and the receiver only listens.
`timescale 1ns/1ns
interface rtc_link_if;
    logic cs;
    logic sclk;
    logic serial_config_port;
    modport dev (input cs, input sclk, input serial_config_port);
    modport host (output cs, output sclk, output serial_config_port);
endinterface

// ==== rtc_dev_clk.sv ====
// Receiver end: clock source selection and RC trim measurement.
// Assumes a serial clock that runs only while chip select is high, and sys_clk standing for the RC oscillator.
`timescale 1ns/1ns
module rtc_dev_clk (
    // Link
    rtc_link_if.dev link,
    // System clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Configuration
    input wire logic xtalSel,
    input wire logic powerDown,
    // Status
    output logic rtcFromXtal,
    output logic rcOn,
    output logic calBusy,
    output logic trimValid,
    output logic [rtc_pkg::TRIM_W-1:0] trimValue
);
    import rtc_pkg::*;

    logic [2:0] bitCnt;
    logic [6:0] cmdShift;
    logic [6:0] refCnt;
    logic started;
    logic finished;
    logic [SYNC_W-1:0] startSync;
    logic [SYNC_W-1:0] finSync;
    logic startLvl;
    logic finLvl;
    logic startLvlQ;
    logic finLvlQ;
    logic measuring;
    logic [TRIM_W-1:0] measCnt;

    // Frame logic is cleared by chip select low, since the serial clock stops outside frames.
    always_ff @(posedge link.sclk or negedge link.cs) begin
        if (!link.cs) begin
            bitCnt <= 3'h0;
            cmdShift <= 7'h00;
            started <= 1'b0;
        end else if (!started) begin
            cmdShift <= {cmdShift[5:0], link.serial_config_port};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
                started <= ({cmdShift, link.serial_config_port} == TRIM_CMD); // see (R2)
            end
        end
    end

    always_ff @(posedge link.sclk or negedge link.cs) begin
        if (!link.cs) begin
            refCnt <= 7'h00;
            finished <= 1'b0;
        end else if (started && !finished) begin
            refCnt <= refCnt + 7'h01;
            if (refCnt == 7'(REF_EDGES - 1)) begin
                finished <= 1'b1; // see (R6)
            end
        end
    end

    // Both frame levels cross by three flops; a level counts once the last two agree.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            startSync <= '0;
            finSync <= '0;
            startLvl <= 1'b0;
            finLvl <= 1'b0;
            startLvlQ <= 1'b0;
            finLvlQ <= 1'b0;
        end else begin
            startSync <= {startSync[SYNC_W-2:0], started};
            finSync <= {finSync[SYNC_W-2:0], finished};
            if (startSync[1] == startSync[2]) begin
                startLvl <= startSync[2];
            end
            if (finSync[1] == finSync[2]) begin
                finLvl <= finSync[2];
            end
            startLvlQ <= startLvl;
            finLvlQ <= finLvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rcOn <= 1'b0;
            rtcFromXtal <= 1'b0;
        end else begin
            rcOn <= !powerDown && !xtalSel; // see (R3)
            rtcFromXtal <= xtalSel; // see (R1)
        end
    end

    // The trim lives only in flops, so losing the oscillator loses it.
    always_ff @(posedge sys_clk) begin
        if (srst || !rcOn) begin
            measuring <= 1'b0; // see (R3)
            measCnt <= '0;
            trimValid <= 1'b0; // see (R4)
            trimValue <= '0;
        end else if (startLvl && !startLvlQ) begin
            measuring <= 1'b1; // see (R2)
            measCnt <= '0;
        end else if (measuring) begin
            if (finLvl && !finLvlQ) begin
                measuring <= 1'b0;
                trimValue <= measCnt; // see (R6)
                trimValid <= 1'b1;
            end else if (!startLvl) begin
                measuring <= 1'b0; // see (R13)
            end else if (measCnt != '1) begin
                measCnt <= measCnt + TRIM_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            calBusy <= 1'b0;
        end else begin
            calBusy <= measuring;
        end
    end
endmodule

// ==== rtc_asserts.sv ====
// Checker for the trim link and the receiver's clock status.
// Assumes every watched signal lives on sys_clk and the host drives the link from flops.
`timescale 1ns/1ns
module rtc_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link
    input wire logic cs,
    input wire logic sclk,
    input wire logic serial_config_port,
    // Receiver configuration and status
    input wire logic xtalSel,
    input wire logic powerDown,
    input wire logic rtcFromXtal,
    input wire logic rcOn,
    input wire logic calBusy,
    input wire logic trimValid
);
    import rtc_pkg::*;
    logic sclkQ;
    logic [7:0] edges;
    logic [7:0] cmd;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge sys_clk) begin
        sclkQ <= sclk;
    end
    // Edges are counted one cycle late, which is safe because the host holds each level for several cycles.
    always_ff @(posedge sys_clk) begin
        if (srst || !cs) begin
            edges <= 8'h00;
        end else if (sclk && !sclkQ) begin
            edges <= edges + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (cs && sclk && !sclkQ && edges < 8'h08) begin
            cmd <= {cmd[6:0], serial_config_port};
        end
    end
    sequence s_rc_lost;
        $fell(rcOn);
    endsequence
    sequence s_frame_end;
        $fell(cs);
    endsequence
    property p_src_xtal; xtalSel |=> rtcFromXtal; endproperty
    property p_src_rc; !xtalSel |=> !rtcFromXtal; endproperty
    property p_rc_off; (xtalSel || powerDown) |=> !rcOn; endproperty
    property p_trim_lost; s_rc_lost |=> !trimValid; endproperty
    property p_idle_clk; !cs |-> !sclk; endproperty
    property p_frame_len; s_frame_end |-> edges == 8'h49; endproperty
    property p_frame_cmd; s_frame_end |-> cmd == TRIM_CMD; endproperty
    property p_busy_cs; $rose(calBusy) |-> cs; endproperty
    a_src_xtal: assert property (p_src_xtal) else $error("crystal not selected");
    a_src_rc: assert property (p_src_rc) else $error("rc not selected");
    a_rc_off: assert property (p_rc_off) else $error("rc left on");
    a_trim_lost: assert property (p_trim_lost) else $error("trim kept after rc off");
    a_idle_clk: assert property (p_idle_clk) else $error("serial clock outside frame");
    a_frame_len: assert property (p_frame_len) else $error("wrong edge count in frame");
    a_frame_cmd: assert property (p_frame_cmd) else $error("wrong command in frame");
    a_busy_cs: assert property (p_busy_cs) else $error("calibration started without frame");
endmodule

// ==== rtc_source_select_and_rc_trim_test.sv ====
// Testbench: host and receiver joined, plus a second receiver on a link driven here.
// Assumes the package constants and an APB slave that answers with pready.
`timescale 1ns/1ns
module rtc_source_select_and_rc_trim_test;
    import rtc_pkg::*;
    localparam int HALF = 4;
    localparam int NOM = 65 * 2 * HALF;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, xtalSel, powerDown, extClk, scanMode, onOffMode;
    logic rtcFromXtal, rcOn, calBusy, trimValid, validB, busyB;
    logic [2:0] chanEn;
    logic [TRIM_W-1:0] trimValue, trimB, keepB;
    logic [4:0] cw [6] = '{5'h0D, 5'h0B, 5'h12, 5'h11, 5'h19, 5'h07};
    logic [4:0] ce [6] = '{5'h0D, 5'h0D, 5'h0D, 5'h11, 5'h11, 5'h07};
    int failures = 0;
    int compares = 0;
    int tog;
    rtc_link_if linkA ();
    rtc_link_if linkB ();
    rtc_host_trim #(.REF_HALF(HALF)) i_rtc_host_trim (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(linkA.host), .xtalSel(xtalSel), .powerDown(powerDown), .extClk(extClk),
        .chanEn(chanEn), .scanMode(scanMode), .onOffMode(onOffMode));
    rtc_dev_clk i_rtc_dev_clk (.link(linkA.dev), .sys_clk(sys_clk), .srst(srst), .xtalSel(xtalSel),
        .powerDown(powerDown), .rtcFromXtal(rtcFromXtal), .rcOn(rcOn), .calBusy(calBusy),
        .trimValid(trimValid), .trimValue(trimValue));
    rtc_dev_clk i_rtc_dev_clk_b (.link(linkB.dev), .sys_clk(sys_clk), .srst(srst), .xtalSel(xtalSel),
        .powerDown(powerDown), .rtcFromXtal(), .rcOn(), .calBusy(busyB), .trimValid(validB), .trimValue(trimB));
    rtc_asserts i_rtc_asserts (.sys_clk(sys_clk), .srst(srst), .cs(linkA.cs), .sclk(linkA.sclk),
        .serial_config_port(linkA.serial_config_port), .xtalSel(xtalSel), .powerDown(powerDown), .rtcFromXtal(rtcFromXtal),
        .rcOn(rcOn), .calBusy(calBusy), .trimValid(trimValid));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
        check(err, 1'b0);
    endtask
    // A trim request is refused while power down or crystal is still set, so both are cleared first.
    task automatic trim();
        apb(1'b1, CTRL_OFF, 32'h00000000);
        apb(1'b1, CTRL_OFF, 32'h00000004);
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, STAT_OFF, 32'h00000000);
            if (rd[STAT_TRIMMED] === 1'b1) break;
        end
    endtask
    // The bench makes this serial clock itself at 30 ns; it stands still outside the frame.
    task automatic frame(input logic [7:0] c, input int n);
        @(posedge sys_clk);
        linkB.cs <= 1'b1;
        for (int i = 0; i < 8 + n; i++) begin
            linkB.serial_config_port <= (i < 8) ? c[7 - i] : 1'b0;
            #15 linkB.sclk = 1'b1;
            #15 linkB.sclk = 1'b0;
        end
        repeat (10) @(posedge sys_clk);
        linkB.cs <= 1'b0;
        linkB.serial_config_port <= ~linkB.serial_config_port;
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    initial begin
        linkB.cs = 1'b0;
        linkB.sclk = 1'b0;
        linkB.serial_config_port = 1'b0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rdchk(CTRL_OFF, 32'h00000000);
        rdchk(STAT_OFF, 32'h00000000);
        rdchk(CHAN_OFF, 32'h00000007);
        apb(1'b0, 12'h00C, 32'h00000000);
        check(err, 1'b1);
        frame(8'h00, 65);
        check(validB, 1'b0);
        frame(TRIM_CMD, 65);
        check(validB, 1'b1);
        check(trimB >= 16'h0024 && trimB <= 16'h0029, 1'b1);
        keepB = trimB;
        frame(TRIM_CMD, 30);
        check(trimB, keepB);
        check(validB, 1'b1);
        // The abandoned measurement must stop once the dropped frame has crossed over.
        repeat (8) @(posedge sys_clk);
        check(busyB, 1'b0);
        trim();
        check(trimValid, 1'b1);
        check(trimValue >= NOM - 16 && trimValue <= NOM + 8, 1'b1);
        rdchk(STAT_OFF, 32'h00000002);
        apb(1'b1, CTRL_OFF, 32'h00000001);
        repeat (4) @(posedge sys_clk);
        check(rtcFromXtal, 1'b1);
        check(rcOn, 1'b0);
        check(trimValid | validB, 1'b0);
        rdchk(STAT_OFF, 32'h00000000);
        apb(1'b1, CTRL_OFF, 32'h00000005);
        rdchk(STAT_OFF, 32'h00000004);
        apb(1'b1, STAT_OFF, 32'h00000004);
        apb(1'b1, CTRL_OFF, 32'h0000000B);
        repeat (20) @(posedge sys_clk) check(extClk, 1'b1);
        apb(1'b1, CTRL_OFF, 32'h00000009);
        tog = 0;
        repeat (40) @(posedge sys_clk) tog += (extClk === 1'b0);
        check(tog != 0, 1'b1);
        apb(1'b1, CTRL_OFF, 32'h00000002);
        repeat (4) @(posedge sys_clk);
        check({rcOn, rtcFromXtal}, 2'b00);
        trim();
        check(rcOn, 1'b1);
        check(trimValid, 1'b1);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, CHAN_OFF, {27'h0, cw[i]});
            rdchk(CHAN_OFF, {27'h0, ce[i]});
        end
        check({onOffMode, scanMode, chanEn}, 5'h07);
        test_done();
    end
endmodule
